// ==== sfds_map.vh ====
`ifndef SFDS_MAP_VH
`define SFDS_MAP_VH

// clock rate and documented times
`define SFDS_CLK_MHZ 200
`define SFDS_CHECK_US 1000
`define SFDS_DIAG_US 100000
`define SFDS_CHECK_CYC 25'h30d40
`define SFDS_DIAG_CYC 25'h1312d00
`define SFDS_CNT_W 25

// first instruction byte fields
`define SFDS_IB1_DIAG_EN 6
`define SFDS_IB1_OFFSET_EN 5
`define SFDS_IB1_GAIN_FRONT 4
`define SFDS_IB1_GAIN_REAR 3
`define SFDS_IB1_RESET 8'h00

// second instruction byte fields
`define SFDS_IB2_THR_LOW 7
`define SFDS_IB2_STBY_OFF 4
`define SFDS_IB2_LINE_DIAG 3
`define SFDS_IB2_AC_EN 2
`define SFDS_IB2_RESET 8'h00

// per-channel result word
`define SFDS_RES_W 4
`define SFDS_RES_GND 0
`define SFDS_RES_VS 1
`define SFDS_RES_SHORTED 2
`define SFDS_RES_OPEN 3

// positive output is the test-current source on these channels
`define SFDS_POS_SRC_MASK 4'h6

// field positions in the synchronised sense vector
`define SFDS_SYN_POSGND 0
`define SFDS_SYN_NEGGND 4
`define SFDS_SYN_VS 8
`define SFDS_SYN_SHORTED 12
`define SFDS_SYN_OPEN 16
`define SFDS_SYN_OVL 20
`define SFDS_SYN_OFFSET 24
`define SFDS_SYN_PEAK 28
`define SFDS_SYN_W 32

// peaks needed to call a tweeter present
`define SFDS_PEAK_MIN 2'h3

`endif

// ==== sfds_res_mem.v ====
`timescale 1ns/10ps
`include "sfds_map.vh"

module sfds_res_mem (
	// clock and reset
	input wire clock,
	input wire resetn,
	// write side, one enable per channel
	input wire [3:0] wr_en,
	input wire [4*`SFDS_RES_W-1:0] wr_data,
	input wire clr,
	// registered read side
	input wire [1:0] rd_addr,
	output reg [`SFDS_RES_W-1:0] rd_data
);
	reg [`SFDS_RES_W-1:0] word_r [0:3];
	integer k;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (k = 0; k < 4; k = k + 1) begin
				word_r[k] <= {`SFDS_RES_W{1'b0}};
			end
			rd_data <= {`SFDS_RES_W{1'b0}};
		end else begin
			// a fresh result written with the clear is kept
			for (k = 0; k < 4; k = k + 1) begin
				if (wr_en[k]) begin
					word_r[k] <= wr_data[k*`SFDS_RES_W +: `SFDS_RES_W];
				end else if (clr) begin
					word_r[k] <= {`SFDS_RES_W{1'b0}};
				end
			end
			rd_data <= word_r[rd_addr];
		end
	end
endmodule // sfds_res_mem

// ==== sfds_diag_seq.v ====
`timescale 1ns/10ps
`include "sfds_map.vh"

// How it works
// - standby exit with diagnostics requested runs turn-on load test for four fault kinds
// - turn-on result stays stored until a host read arms a new pulse
// - combined standby exit and enable: pulse first, stage standby, outputs high impedance
// - once biased, permanent diagnostics; turn-on result kept until a short appears
// - output status captured at end of the 100 ms test pulse
// - load thresholds change only with low gain plus line-driver diagnostic mode
// - diagnostics off: shut faulted channel, recheck every 1 ms, restart when clear
// - diagnostics on: overload triggering protection starts the procedure itself
// - recheck 1 ms after overload; if clear, skip diagnostic, channel active again
// - overload still present at recheck starts a 100 ms diagnostic cycle
// - after a cycle channel goes to restart mode; next cycle armed by host read
// - offset beyond 2 V flagged only if it persists the whole window
// - offset window runs from previous read or enable bit set to current read
// - protection firing during measurement suppresses offset and AC load results
// - AC load detection by peak current enabled by second byte bit 2
// - second byte bit 7 selects the high or low peak-current threshold pair
// - tweeter present only with at least 3 peaks over threshold, else open
// - several faults: at least one reported, rest over read and removal cycles
// - double fault priority: source ground plus supply both, supply beats load faults
// - positive output sources test current on channels 3 and 2, negative on 4 and 1
// - permanent diagnostics never report open load; only next turn-on test does
// - each host read restarts cycles and returns the previous cycle's data
// - first byte bit 6 enables diagnostics when set, defeats them when clear
module sfds_diag_seq #(
	parameter [`SFDS_CNT_W-1:0] CHECK_CYCLES = `SFDS_CHECK_CYC,
	parameter [`SFDS_CNT_W-1:0] DIAG_CYCLES = `SFDS_DIAG_CYC
) (
	// clock and reset
	input wire clock,
	input wire resetn,
	// instruction bytes from the bus front end
	input wire ib_write,
	input wire [7:0] first_instruction_byte,
	input wire [7:0] second_instruction_byte,
	input wire host_read,
	// analog comparator flags, one bit per channel, asynchronous
	input wire [3:0] pos_out_gnd,
	input wire [3:0] neg_out_gnd,
	input wire [3:0] out_short_vs,
	input wire [3:0] load_shorted,
	input wire [3:0] load_open,
	input wire [3:0] overload,
	input wire [3:0] offset_over,
	input wire [3:0] peak_over,
	// power stage control
	output reg stage_standby_r,
	output reg outputs_hiz_r,
	output reg test_pulse_r,
	output reg [3:0] ch_shutdown_r,
	output reg [3:0] ch_restart_r,
	// analog threshold selection
	output reg load_thr_line_front_r,
	output reg load_thr_line_rear_r,
	output reg current_thr_low_r,
	output reg ac_detect_en_r,
	// diagnostic results
	output reg [4*`SFDS_RES_W-1:0] report_r,
	output reg [3:0] offset_high_r,
	output reg [3:0] open_tweeter_r
);
	localparam [1:0] ST_STBY = 2'h0;
	localparam [1:0] ST_PULSE = 2'h1;
	localparam [1:0] ST_ACT = 2'h2;
	localparam [1:0] CH_RUN = 2'h0;
	localparam [1:0] CH_CHECK = 2'h1;
	localparam [1:0] CH_DIAG = 2'h2;

	reg [7:0] ib1_r, ib2_r;
	reg [`SFDS_SYN_W-1:0] sync1_r, sync2_r;
	reg [1:0] st_r, st_nxt, pub_addr_r, pub_ch_r;
	reg [`SFDS_CNT_W-1:0] tmr_r, tmr_nxt;
	reg ton_capture, pulse_armed_r, mem_clr_r, pub_busy_r, pub_cap_r;
	reg [1:0] ch_st_r [0:3];
	reg [`SFDS_CNT_W-1:0] ch_cnt_r [0:3];
	reg [3:0] perm_armed_r, off_persist_r, off_ovl_r, ac_ovl_r, peak_prev_r, mem_we_r;
	reg [1:0] peak_cnt_r [0:3];
	reg [4*`SFDS_RES_W-1:0] mem_wd_r;
	wire [`SFDS_RES_W-1:0] mem_rd;
	wire off_start, ac_start;
	integer i, m;

	// one result word per channel, by double-fault priority
	function [`SFDS_RES_W-1:0] resolve;
		input integer ch;
		input [`SFDS_SYN_W-1:0] vec;
		input turn_on;
		reg pos_src, source_gnd, sink_gnd;
		begin
			pos_src = |((`SFDS_POS_SRC_MASK >> ch) & 4'h1);
			source_gnd = pos_src ? vec[`SFDS_SYN_POSGND + ch] : vec[`SFDS_SYN_NEGGND + ch];
			sink_gnd = pos_src ? vec[`SFDS_SYN_NEGGND + ch] : vec[`SFDS_SYN_POSGND + ch];
			resolve = {`SFDS_RES_W{1'b0}};
			if (source_gnd && vec[`SFDS_SYN_VS + ch]) begin
				resolve[`SFDS_RES_GND] = 1'b1;
				resolve[`SFDS_RES_VS] = 1'b1;
			end else if (source_gnd) begin
				resolve[`SFDS_RES_GND] = 1'b1;
			end else if (vec[`SFDS_SYN_VS + ch]) begin
				resolve[`SFDS_RES_VS] = 1'b1;
			end else if (sink_gnd && vec[`SFDS_SYN_OPEN + ch] && turn_on) begin
				resolve[`SFDS_RES_OPEN] = 1'b1;
			end else if (sink_gnd) begin
				resolve[`SFDS_RES_GND] = 1'b1;
			end else if (vec[`SFDS_SYN_SHORTED + ch]) begin
				resolve[`SFDS_RES_SHORTED] = 1'b1;
			end else if (vec[`SFDS_SYN_OPEN + ch] && turn_on) begin
				resolve[`SFDS_RES_OPEN] = 1'b1;
			end
		end
	endfunction

	// window starts: a read, or the enable bit going from 0 to 1
	assign off_start = host_read |
		(ib_write & first_instruction_byte[`SFDS_IB1_OFFSET_EN] & ~ib1_r[`SFDS_IB1_OFFSET_EN]);
	assign ac_start = host_read |
		(ib_write & second_instruction_byte[`SFDS_IB2_AC_EN] & ~ib2_r[`SFDS_IB2_AC_EN]);

	sfds_res_mem u_sfds_res_mem (
		.clock(clock),
		.resetn(resetn),
		.wr_en(mem_we_r),
		.wr_data(mem_wd_r),
		.clr(mem_clr_r),
		.rd_addr(pub_addr_r),
		.rd_data(mem_rd)
	);

	// device-level sequence: standby, turn-on pulse, biased
	always @* begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		ton_capture = 1'b0;
		case (st_r)
			ST_STBY: begin
				if (ib2_r[`SFDS_IB2_STBY_OFF]) begin
					if (ib1_r[`SFDS_IB1_DIAG_EN] && pulse_armed_r) begin
						st_nxt = ST_PULSE;
						tmr_nxt = {`SFDS_CNT_W{1'b0}};
					end else begin
						st_nxt = ST_ACT;
					end
				end
			end
			ST_PULSE: begin
				if (!ib2_r[`SFDS_IB2_STBY_OFF]) begin
					st_nxt = ST_STBY;
				end else if (tmr_r == DIAG_CYCLES - 1'b1) begin
					ton_capture = 1'b1;
					st_nxt = ST_ACT;
				end else begin
					tmr_nxt = tmr_r + 1'b1;
				end
			end
			ST_ACT: begin
				if (!ib2_r[`SFDS_IB2_STBY_OFF]) begin
					st_nxt = ST_STBY;
				end
			end
			default: begin
				st_nxt = ST_STBY;
			end
		endcase
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ib1_r <= `SFDS_IB1_RESET;
			ib2_r <= `SFDS_IB2_RESET;
			sync1_r <= {`SFDS_SYN_W{1'b0}};
			sync2_r <= {`SFDS_SYN_W{1'b0}};
			st_r <= ST_STBY;
			tmr_r <= {`SFDS_CNT_W{1'b0}};
			pulse_armed_r <= 1'b1;
			stage_standby_r <= 1'b1;
			outputs_hiz_r <= 1'b1;
			test_pulse_r <= 1'b0;
			load_thr_line_front_r <= 1'b0;
			load_thr_line_rear_r <= 1'b0;
			current_thr_low_r <= 1'b0;
			ac_detect_en_r <= 1'b0;
		end else begin
			if (ib_write) begin
				ib1_r <= first_instruction_byte;
				ib2_r <= second_instruction_byte;
			end
			// comparators are analog and free running
			sync1_r <= {peak_over, offset_over, overload, load_open,
				load_shorted, out_short_vs, neg_out_gnd, pos_out_gnd};
			sync2_r <= sync1_r;
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			// stage held in standby with floating outputs during the pulse
			stage_standby_r <= (st_nxt != ST_ACT);
			outputs_hiz_r <= (st_nxt != ST_ACT);
			test_pulse_r <= (st_nxt == ST_PULSE);
			if (host_read) begin
				pulse_armed_r <= 1'b1;
			end else if (ton_capture) begin
				pulse_armed_r <= 1'b0;
			end
			load_thr_line_front_r <= ib1_r[`SFDS_IB1_GAIN_FRONT] & ib2_r[`SFDS_IB2_LINE_DIAG];
			load_thr_line_rear_r <= ib1_r[`SFDS_IB1_GAIN_REAR] & ib2_r[`SFDS_IB2_LINE_DIAG];
			current_thr_low_r <= ib2_r[`SFDS_IB2_THR_LOW];
			ac_detect_en_r <= ib2_r[`SFDS_IB2_AC_EN];
		end
	end

	// per-channel overload handling and result capture
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 4; i = i + 1) begin
				ch_st_r[i] <= CH_RUN;
				ch_cnt_r[i] <= {`SFDS_CNT_W{1'b0}};
			end
			perm_armed_r <= 4'hf;
			ch_shutdown_r <= 4'h0;
			ch_restart_r <= 4'hf;
			mem_we_r <= 4'h0;
			mem_wd_r <= {4*`SFDS_RES_W{1'b0}};
		end else begin
			mem_we_r <= 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				if (ton_capture) begin
					mem_we_r[i] <= 1'b1;
					mem_wd_r[i*`SFDS_RES_W +: `SFDS_RES_W] <= resolve(i, sync2_r, 1'b1);
				end
				if (st_r != ST_ACT) begin
					ch_st_r[i] <= CH_RUN;
					ch_shutdown_r[i] <= 1'b0;
				end else begin
					case (ch_st_r[i])
						CH_RUN: begin
							if (sync2_r[`SFDS_SYN_OVL + i]) begin
								ch_st_r[i] <= CH_CHECK;
								ch_cnt_r[i] <= {`SFDS_CNT_W{1'b0}};
								ch_shutdown_r[i] <= 1'b1;
							end
						end
						CH_CHECK: begin
							if (ch_cnt_r[i] == CHECK_CYCLES - 1'b1) begin
								ch_cnt_r[i] <= {`SFDS_CNT_W{1'b0}};
								if (!sync2_r[`SFDS_SYN_OVL + i]) begin
									ch_st_r[i] <= CH_RUN;
									ch_shutdown_r[i] <= 1'b0;
								end else if (ib1_r[`SFDS_IB1_DIAG_EN] && perm_armed_r[i]) begin
									ch_st_r[i] <= CH_DIAG;
								end
							end else begin
								ch_cnt_r[i] <= ch_cnt_r[i] + 1'b1;
							end
						end
						CH_DIAG: begin
							if (ch_cnt_r[i] == DIAG_CYCLES - 1'b1) begin
								// no short seen: turn-on result stays
								if (|resolve(i, sync2_r, 1'b0)) begin
									mem_we_r[i] <= 1'b1;
									mem_wd_r[i*`SFDS_RES_W +: `SFDS_RES_W] <= resolve(i, sync2_r, 1'b0);
								end
								ch_st_r[i] <= CH_CHECK;
								ch_cnt_r[i] <= {`SFDS_CNT_W{1'b0}};
							end else begin
								ch_cnt_r[i] <= ch_cnt_r[i] + 1'b1;
							end
						end
						default: begin
							ch_st_r[i] <= CH_RUN;
						end
					endcase
				end
				// a read re-arms even a cycle ending in the same clock
				if (host_read) begin
					perm_armed_r[i] <= 1'b1;
				end else if (st_r == ST_ACT && ch_st_r[i] == CH_DIAG && ch_cnt_r[i] == DIAG_CYCLES - 1'b1) begin
					perm_armed_r[i] <= 1'b0;
				end
				ch_restart_r[i] <= ~(ib1_r[`SFDS_IB1_DIAG_EN] & perm_armed_r[i]);
			end
		end
	end

	// offset and AC load windows, closed by a host read
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			off_persist_r <= 4'h0;
			off_ovl_r <= 4'h0;
			ac_ovl_r <= 4'h0;
			peak_prev_r <= 4'h0;
			offset_high_r <= 4'h0;
			open_tweeter_r <= 4'h0;
			for (m = 0; m < 4; m = m + 1) begin
				peak_cnt_r[m] <= 2'h0;
			end
		end else begin
			peak_prev_r <= sync2_r[`SFDS_SYN_PEAK +: 4];
			for (m = 0; m < 4; m = m + 1) begin
				if (host_read) begin
					// last-cycle evidence still counts toward the closing window
					offset_high_r[m] <= ib1_r[`SFDS_IB1_OFFSET_EN] & off_persist_r[m] &
						sync2_r[`SFDS_SYN_OFFSET + m] & ~off_ovl_r[m] & ~sync2_r[`SFDS_SYN_OVL + m];
					open_tweeter_r[m] <= ib2_r[`SFDS_IB2_AC_EN] & ~ac_ovl_r[m] &
						~sync2_r[`SFDS_SYN_OVL + m] & (peak_cnt_r[m] != `SFDS_PEAK_MIN);
				end
				// an overload on the start cycle still taints the new window
				if (off_start) begin
					off_persist_r[m] <= 1'b1;
					off_ovl_r[m] <= sync2_r[`SFDS_SYN_OVL + m];
				end else begin
					if (!sync2_r[`SFDS_SYN_OFFSET + m]) begin
						off_persist_r[m] <= 1'b0;
					end
					if (sync2_r[`SFDS_SYN_OVL + m]) begin
						off_ovl_r[m] <= 1'b1;
					end
				end
				if (ac_start) begin
					ac_ovl_r[m] <= sync2_r[`SFDS_SYN_OVL + m];
					peak_cnt_r[m] <= 2'h0;
				end else begin
					if (sync2_r[`SFDS_SYN_OVL + m]) begin
						ac_ovl_r[m] <= 1'b1;
					end
					// saturating count of rising peak edges
					if (sync2_r[`SFDS_SYN_PEAK + m] && !peak_prev_r[m] && peak_cnt_r[m] != `SFDS_PEAK_MIN) begin
						peak_cnt_r[m] <= peak_cnt_r[m] + 1'b1;
					end
				end
			end
		end
	end

	// read publishes the stored cycle, then clears for the next one
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pub_busy_r <= 1'b0;
			pub_addr_r <= 2'h0;
			pub_cap_r <= 1'b0;
			pub_ch_r <= 2'h0;
			mem_clr_r <= 1'b0;
			report_r <= {4*`SFDS_RES_W{1'b0}};
		end else begin
			mem_clr_r <= 1'b0;
			pub_cap_r <= pub_busy_r;
			pub_ch_r <= pub_addr_r;
			if (pub_busy_r) begin
				pub_addr_r <= pub_addr_r + 1'b1;
				if (pub_addr_r == 2'h3) begin
					pub_busy_r <= 1'b0;
					mem_clr_r <= 1'b1;
				end
			end else if (host_read) begin
				pub_busy_r <= 1'b1;
				pub_addr_r <= 2'h0;
			end
			if (pub_cap_r) begin
				report_r[pub_ch_r*`SFDS_RES_W +: `SFDS_RES_W] <= mem_rd;
			end
		end
	end
endmodule // sfds_diag_seq

// ==== sfds_host_model.sv ====
`timescale 1ns/10ps
module sfds_host_model (
	// clock
	input wire clock,
	// instruction write
	output reg ib_write,
	output reg [7:0] first_instruction_byte,
	output reg [7:0] second_instruction_byte,
	// result read
	output reg host_read
);
	initial begin
		ib_write = 1'b0;
		host_read = 1'b0;
		first_instruction_byte = 8'h00;
		second_instruction_byte = 8'h00;
	end

	// both bytes travel together; bytes stay put after the pulse
	task write_bytes(input [7:0] b1, input [7:0] b2);
		@(posedge clock);
		#1;
		ib_write = 1'b1;
		first_instruction_byte = b1;
		second_instruction_byte = b2;
		@(posedge clock);
		#1;
		ib_write = 1'b0;
	endtask

	// spacing kept short for run time; a real host polls far slower
	task read_result;
		@(posedge clock);
		#1;
		host_read = 1'b1;
		@(posedge clock);
		#1;
		host_read = 1'b0;
		repeat (8) @(posedge clock);
		#1;
	endtask
endmodule // sfds_host_model

// ==== sfds_diag_seq_properties.sv ====
`timescale 1ns/10ps
module sfds_props #(
	parameter [24:0] CHECK_CYCLES = 25'd20,
	parameter [24:0] DIAG_CYCLES = 25'd50
) (
	// clock and reset
	input wire clock,
	input wire resetn,
	// host and analog side
	input wire ib_write,
	input wire [7:0] first_instruction_byte,
	input wire [7:0] second_instruction_byte,
	input wire host_read,
	input wire [3:0] overload,
	// design outputs
	input wire stage_standby_r,
	input wire outputs_hiz_r,
	input wire test_pulse_r,
	input wire [3:0] ch_shutdown_r,
	input wire load_thr_line_front_r,
	input wire current_thr_low_r,
	input wire ac_detect_en_r,
	input wire [3:0] offset_high_r,
	input wire [3:0] open_tweeter_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_stby_hiz;
		stage_standby_r == outputs_hiz_r;
	endproperty
	a_stby_hiz: assert property (p_stby_hiz) else $error("standby and hiz differ");
	property p_pulse_stby;
		test_pulse_r |-> stage_standby_r && outputs_hiz_r;
	endproperty
	a_pulse_stby: assert property (p_pulse_stby) else $error("pulse outside standby");
	property p_thr_low;
		ib_write |-> ##2 current_thr_low_r == $past(second_instruction_byte[7], 2);
	endproperty
	a_thr_low: assert property (p_thr_low) else $error("current threshold select wrong");
	property p_ac_en;
		ib_write |-> ##2 ac_detect_en_r == $past(second_instruction_byte[2], 2);
	endproperty
	a_ac_en: assert property (p_ac_en) else $error("ac detect enable wrong");
	property p_line_front;
		ib_write |-> ##2 load_thr_line_front_r ==
			($past(first_instruction_byte[4], 2) & $past(second_instruction_byte[3], 2));
	endproperty
	a_line_front: assert property (p_line_front) else $error("line threshold select wrong");
	property p_shut_cause;
		$rose(ch_shutdown_r[0]) |-> $past(overload[0], 2) || $past(overload[0], 3) ||
			$past(overload[0], 4) || $past(overload[0], 5);
	endproperty
	a_shut_cause: assert property (p_shut_cause) else $error("shutdown without overload");
	property p_shut_hold;
		$rose(ch_shutdown_r[0]) |-> ch_shutdown_r[0] [*8];
	endproperty
	a_shut_hold: assert property (p_shut_hold) else $error("recheck came too early");
	property p_tw_off;
		host_read && !ac_detect_en_r |=> open_tweeter_r == 4'h0;
	endproperty
	a_tw_off: assert property (p_tw_off) else $error("open tweeter with ac detect off");
	property p_res_stand;
		!$past(host_read) |-> $stable(offset_high_r) && $stable(open_tweeter_r);
	endproperty
	a_res_stand: assert property (p_res_stand) else $error("result changed without read");
endmodule // sfds_props

bind sfds_diag_seq sfds_props #(.CHECK_CYCLES(CHECK_CYCLES), .DIAG_CYCLES(DIAG_CYCLES)) u_sfds_props (.*);

// ==== sfds_diag_seq_tb.sv ====
`timescale 1ns/10ps
`define SFDS_CHK(n, e, g) begin compares++; if ((e) !== (g)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module sfds_diag_seq_tb;
	reg clock = 1'b0;
	reg resetn = 1'b0;
	reg [3:0] pos_out_gnd = 4'h0, neg_out_gnd = 4'h0, out_short_vs = 4'h0, load_shorted = 4'h0;
	reg [3:0] load_open = 4'h0, overload = 4'h0, offset_over = 4'h0, peak_over = 4'h0;
	wire ib_write, host_read;
	wire [7:0] first_instruction_byte, second_instruction_byte;
	wire stage_standby_r, outputs_hiz_r, test_pulse_r, load_thr_line_front_r, load_thr_line_rear_r;
	wire current_thr_low_r, ac_detect_en_r;
	wire [3:0] ch_shutdown_r, ch_restart_r, offset_high_r, open_tweeter_r;
	wire [15:0] report_r;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int seed_v, k, t;
	logic [23:0] exp_q[$];
	logic [23:0] note;
	reg [3:0] rnd_off, rnd_pk, ovl_ch, off_keep;

	always #2.5 clock = ~clock;

	sfds_host_model u_sfds_host_model (.*);
	sfds_diag_seq #(.CHECK_CYCLES(25'd20), .DIAG_CYCLES(25'd50)) u_sfds_diag_seq (.*);

	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// expected result noted before the read goes out
	task read_exp(input [15:0] rep, input [3:0] off, input [3:0] tw);
		exp_q.push_back({rep, off, tw});
		u_sfds_host_model.read_result;
	endtask

	task tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// report words settle 5 edges after the read
	initial forever begin
		@(posedge clock);
		if (host_read === 1'b1) begin
			repeat (7) @(posedge clock);
			#1;
			note = exp_q.pop_front();
			`SFDS_CHK("report", note[23:8], report_r)
			`SFDS_CHK("offset", note[7:4], offset_high_r)
			`SFDS_CHK("tweeter", note[3:0], open_tweeter_r)
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("timeout");
			tally_and_finish;
		end
	end

	initial begin
		seed_v = $urandom(60495);
		repeat (6) @(posedge clock);
		#1;
		resetn = 1'b1;
		// one double fault per channel during the turn-on pulse
		pos_out_gnd = 4'h2;
		neg_out_gnd = 4'h5;
		out_short_vs = 4'ha;
		load_shorted = 4'h9;
		load_open = 4'h4;
		u_sfds_host_model.write_bytes(8'h40, 8'h10);
		step(3);
		`SFDS_CHK("pulse", 3'b111, {test_pulse_r, stage_standby_r, outputs_hiz_r})
		wait (test_pulse_r === 1'b0);
		step(1);
		`SFDS_CHK("standby", 2'b00, {stage_standby_r, outputs_hiz_r})
		{pos_out_gnd, neg_out_gnd, out_short_vs, load_shorted, load_open} = 20'h0;
		read_exp(16'h2831, 4'h0, 4'h0);
		read_exp(16'h0000, 4'h0, 4'h0);
		$display("test turn_on done");
		// offset and tweeter windows, both current thresholds
		// a later window opens at the read, so offset must already stand then
		off_keep = 4'hf;
		for (t = 0; t < 2; t++) begin
			rnd_off = 4'($urandom);
			rnd_pk = 4'($urandom);
			offset_over = rnd_off;
			u_sfds_host_model.write_bytes(8'h60 | {3'h0, t[0], 4'h0}, 8'h14 | {t[0], 3'h0, t[0], 3'h0});
			step(4);
			`SFDS_CHK("thr_low", t[0], current_thr_low_r)
			`SFDS_CHK("line", {t[0], 1'b0}, {load_thr_line_front_r, load_thr_line_rear_r})
			`SFDS_CHK("ac_en", 1'b1, ac_detect_en_r)
			for (k = 0; k < 3; k++) begin
				peak_over = (k < 2) ? 4'hf : rnd_pk;
				step(3);
				peak_over = 4'h0;
				step(3);
			end
			read_exp(16'h0000, rnd_off & off_keep, ~rnd_pk);
			off_keep = rnd_off;
		end
		$display("test offset_ac done");
		// short overload: recheck finds it gone
		ovl_ch = 4'h1 << ($urandom % 4);
		overload = ovl_ch;
		step(3);
		overload = 4'h0;
		step(2);
		`SFDS_CHK("shutdown", ovl_ch, ch_shutdown_r)
		step(30);
		`SFDS_CHK("released", 4'h0, ch_shutdown_r)
		read_exp(16'h0000, rnd_off & ~ovl_ch, ~ovl_ch);
		$display("test transient done");
		// lasting overload with ground short and open load
		offset_over = 4'h0;
		neg_out_gnd = 4'h1;
		load_open = 4'h1;
		overload = 4'h1;
		step(100);
		`SFDS_CHK("restart", 1'b1, ch_restart_r[0])
		{neg_out_gnd, load_open, overload} = 12'h0;
		step(40);
		`SFDS_CHK("cleared", 4'h0, ch_shutdown_r)
		read_exp(16'h0001, 4'h0, 4'he);
		read_exp(16'h0000, 4'h0, 4'hf);
		$display("test permanent done");
		tally_and_finish;
	end
endmodule // sfds_diag_seq_tb
